// [design/result_format_pkg.sv]
// package: constants and types for the converter result formatting block
package result_format_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] offset_result_high = 4'h0;
  localparam logic [3:0] offset_result_low  = 4'h1;
  localparam logic [3:0] offset_control     = 4'h2;
  localparam logic [3:0] offset_status      = 4'h3;

  // ****************************************
  // field positions
  // ****************************************
  localparam int format_bit     = 0;  // control: result_format_select
  localparam int start_bit      = 1;  // control: conversion in progress
  localparam int channel_lsb    = 2;  // control: input_channel_select lsb
  localparam int busy_bit       = 0;  // status: conversion in progress
  localparam int acq_done_bit   = 1;  // status: acquisition interval elapsed

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [7:0] control_reset = 8'h00;
  localparam int clock_mhz          = 125;
  localparam int acquisition_ns     = 4620;
  localparam int acquisition_cycles = (acquisition_ns * clock_mhz + 999) / 1000;
  localparam int conversion_cycles  = 12;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    idle_state     = 2'b00,
    convert_state  = 2'b01
  } conv_state_type;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_pair_type;

endpackage : result_format_pkg

// [design/adc_result_formatting.sv]
// module: result register formatting and conversion sequencing control
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
module adc_result_formatting
  import result_format_pkg::*;
#(
  parameter int result_width  = 10,
  parameter int channel_width = 5
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  // register port
  input  wire logic [3:0]               address,
  input  wire logic [7:0]               write_data,
  input  wire logic                     write_strobe,
  input  wire logic                     read_strobe,
  output logic      [7:0]               read_data,
  // conversion sequencer
  output logic                          conversion_start,
  output logic      [channel_width-1:0] input_channel_select,
  input  wire logic                     conversion_done,
  input  wire logic [result_width-1:0]  conversion_result
);

  // ****************************************
  // formatting function
  // ****************************************
  function automatic result_pair_type format_result(input logic right,
                                                    input logic [9:0] value);
    result_pair_type pair;
    pair = '0;
    if (right) begin
      pair.high = {6'h00, value[9:8]};
      pair.low  = value[7:0];
    end else begin
      pair.high = value[9:2];
      pair.low  = {value[1:0], 6'h00};
    end
    return pair;
  endfunction : format_result

  // ****************************************
  // state
  // ****************************************
  conv_state_type    state;
  conv_state_type    next_state;
  logic              result_format_select;
  logic              next_result_format_select;
  logic [channel_width-1:0] next_input_channel_select;
  logic              next_conversion_start;
  logic [15:0]       acq_count;
  logic [15:0]       next_acq_count;
  logic              busy;
  logic              next_busy;
  result_pair_type   result;
  result_pair_type   next_result;
  logic [7:0]        next_read_data;
  logic              control_write;

  assign control_write = write_strobe && (address == offset_control);

  // control, sequencing and acquisition counter
  always_comb begin
    next_state                = state;
    next_result_format_select = result_format_select;
    next_input_channel_select = input_channel_select;
    next_conversion_start     = 1'b0;
    next_busy                 = busy;
    next_acq_count            = acq_count;
    if (acq_count != 16'h0000) begin
      next_acq_count = acq_count - 16'h0001;
    end
    if (control_write) begin
      next_result_format_select = write_data[format_bit];
      if (write_data[channel_lsb +: channel_width] != input_channel_select) begin
        next_acq_count = 16'(acquisition_cycles);  // restart interval
      end
      next_input_channel_select = write_data[channel_lsb +: channel_width];
    end
    case (state)
      idle_state: begin
        if (control_write && write_data[start_bit]) begin
          next_busy             = 1'b1;
          next_conversion_start = 1'b1;
          next_state            = convert_state;
        end
      end
      convert_state: begin
        if (conversion_done) begin
          next_busy  = 1'b0;
          next_state = idle_state;
        end
      end
      default: begin
        next_state = idle_state;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state                <= idle_state;
      result_format_select <= control_reset[format_bit];
      input_channel_select <= '0;
      conversion_start     <= 1'b0;
      busy                 <= 1'b0;
      acq_count            <= 16'h0000;
    end else begin
      state                <= next_state;
      result_format_select <= next_result_format_select;
      input_channel_select <= next_input_channel_select;
      conversion_start     <= next_conversion_start;
      busy                 <= next_busy;
      acq_count            <= next_acq_count;
    end
  end

  // result registers: software write or atomic load on completion
  always_comb begin
    next_result = result;
    if (write_strobe && (address == offset_result_high)) begin
      next_result.high = write_data;
    end
    if (write_strobe && (address == offset_result_low)) begin
      next_result.low = write_data;
    end
    if ((state == convert_state) && conversion_done) begin
      next_result = format_result(result_format_select, conversion_result[9:0]);
    end
  end

  // no reset: contents hold across resets
  always_ff @(posedge clk) begin
    result <= next_result;
  end

  // read path, data one cycle after the strobe
  always_comb begin
    next_read_data = 8'h00;
    if (read_strobe) begin
      if (address == offset_result_high) begin
        next_read_data = result.high;
      end else if (address == offset_result_low) begin
        next_read_data = result.low;
      end else if (address == offset_control) begin
        next_read_data = 8'h00;
        next_read_data[format_bit] = result_format_select;
        next_read_data[start_bit]  = busy;
        next_read_data[channel_lsb +: channel_width] = input_channel_select;
      end else if (address == offset_status) begin
        next_read_data[busy_bit]     = busy;
        next_read_data[acq_done_bit] = (acq_count == 16'h0000);
      end else begin
        next_read_data = 8'h00;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      read_data <= 8'h00;
    end else begin
      read_data <= next_read_data;
    end
  end

endmodule : adc_result_formatting

// [testbench/adc_result_formatting_assertions.sv]
// checker: port-level assertions for the result formatting block
`timescale 1ns/100ps
module adc_result_formatting_checker
  import result_format_pkg::*;
#(parameter int result_width = 10, parameter int channel_width = 5) (
  // clock, reset and all block ports
  input wire logic clk, reset_n, write_strobe, read_strobe, conversion_start, conversion_done,
  input wire logic [3:0] address,
  input wire logic [7:0] write_data, read_data,
  input wire logic [channel_width-1:0] input_channel_select,
  input wire logic [result_width-1:0] conversion_result
);
  logic busy, fmt, ok, ctl, load, next_busy, next_fmt;
  logic [7:0] hi, lo, next_hi, next_lo;
  // shadow copy of busy, format and both result registers
  always_comb begin
    ctl = write_strobe && address == offset_control;
    load = conversion_done && busy;
    next_fmt = ctl ? write_data[format_bit] : fmt;
    next_busy = !load && ((ctl && write_data[start_bit]) || busy);
    next_hi = (write_strobe && address == offset_result_high) ? write_data : hi;
    next_lo = (write_strobe && address == offset_result_low) ? write_data : lo;
    if (load) begin
      next_hi = fmt ? {6'h00, conversion_result[9:8]} : conversion_result[9:2];
      next_lo = fmt ? conversion_result[7:0] : {conversion_result[1:0], 6'h00};
    end
  end
  // result shadow is never reset, like the registers it follows
  always_ff @(posedge clk) begin
    busy <= reset_n && next_busy;
    fmt <= reset_n && next_fmt;
    ok <= (ok === 1'b1) || load;
    hi <= next_hi;
    lo <= next_lo;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  high_read_a: assert property (ok && read_strobe && address == offset_result_high
    |=> read_data == $past(hi)) else $error("high result read wrong");
  low_read_a: assert property (ok && read_strobe && address == offset_result_low
    |=> read_data == $past(lo)) else $error("low result read wrong");
  idle_zero_a: assert property (!$past(read_strobe) |-> read_data == 8'h00)
    else $error("read data outside read slot");
  start_pulse_a: assert property (conversion_start |=> !conversion_start)
    else $error("start pulse too long");
  start_cause_a: assert property (conversion_start |-> $past(ctl && write_data[1] && !busy))
    else $error("start without start write");
  busy_flag_a: assert property (read_strobe && address == offset_status
    |=> read_data[busy_bit] == $past(busy)) else $error("busy flag wrong");
  load_clear_a: assert property (load ##2 (read_strobe && address == offset_status)
    |=> read_data[busy_bit] == 1'b0) else $error("busy left after load");
  channel_a: assert property (ctl |=> input_channel_select == $past(write_data[6:2]))
    else $error("channel not taken");
  cover property (load && fmt);
  cover property (load && !fmt);
  cover property (conversion_start);
endmodule : adc_result_formatting_checker
bind adc_result_formatting adc_result_formatting_checker #(.result_width(result_width),
  .channel_width(channel_width)) u_chk (.clk, .reset_n, .write_strobe, .read_strobe,
  .conversion_start, .conversion_done, .address, .write_data, .read_data,
  .input_channel_select, .conversion_result);

// [testbench/tb_adc_result_formatting.sv]
// testbench: conversions in both formats, register access, reset retention
`timescale 1ns/100ps
module tb_adc_result_formatting;
  import result_format_pkg::*;
  logic clk = 0, reset_n = 0, write_strobe = 0, read_strobe = 0, conversion_done = 0;
  logic conversion_start;
  logic [3:0] address = 4'h0;
  logic [7:0] write_data = 8'h00, read_data, got;
  logic [4:0] input_channel_select;
  logic [9:0] conversion_result = 10'h000;
  int fail_count = 0, num_checks = 0, cycles = 0;
  // rows: format, result, expected high, expected low
  logic [26:0] rows [4] = '{{1'b0, 10'h3FF, 8'hFF, 8'hC0}, {1'b1, 10'h3FF, 8'h03, 8'hFF},
    {1'b0, 10'h2A5, 8'hA9, 8'h40}, {1'b1, 10'h2A5, 8'h02, 8'hA5}};
  adc_result_formatting u_adc_result_formatting (.clk, .reset_n, .address, .write_data,
    .write_strobe, .read_strobe, .read_data, .conversion_start, .input_channel_select,
    .conversion_done, .conversion_result);
  initial forever #4 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      results();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1 got = read_data;
  endtask : rd
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      $display("BAD %0t got %h want %h", $time, g, e);
      fail_count++;
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      wr(offset_control, {1'b0, 5'(i), 1'b0, rows[i][26]});
      repeat (acquisition_cycles) @(posedge clk);
      chk(8'(input_channel_select), 8'(i));
      wr(offset_control, {1'b0, 5'(i), 1'b1, rows[i][26]});
      #1 chk(8'(conversion_start), 8'h01);
      rd(offset_status);
      chk(got, 8'h03);
      @(posedge clk);
      conversion_result <= rows[i][25:16];
      conversion_done <= 1'b1;
      @(posedge clk);
      conversion_done <= 1'b0;
      rd(offset_status);
      chk(got, 8'h02);
      rd(offset_control);
      chk(got, {1'b0, 5'(i), 1'b0, rows[i][26]});
      rd(offset_result_high);
      chk(got, rows[i][15:8]);
      rd(offset_result_low);
      chk(got, rows[i][7:0]);
    end
    // completion pulse while idle leaves the result alone
    @(posedge clk);
    conversion_done <= 1'b1;
    @(posedge clk);
    conversion_done <= 1'b0;
    rd(offset_result_low);
    chk(got, 8'hA5);
    // software write survives a later reset
    wr(offset_result_high, 8'h5A);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(offset_result_high);
    chk(got, 8'h5A);
    rd(offset_result_low);
    chk(got, 8'hA5);
    results();
  end
endmodule : tb_adc_result_formatting
